/* rtl/lpsc_defines.svh */
// Timing and encoding constants for the low-power state controller.
// Assumes inclusion by bare name from rtl files.
`ifndef LPSC_DEFINES_SVH
`define LPSC_DEFINES_SVH
`define LPSC_SYNC_STAGES 3
`define LPSC_ACK_STOP_GRANT 2'h1
`define LPSC_ACK_MGMT 2'h2
`define LPSC_ACK_NONE 2'h0
`define LPSC_RESET_RELEASE_CLKS 2
`endif

/* rtl/lpsc_pkg.sv */
// Types for the low-power state controller.
// Assumes the defines header is compiled alongside.
package lpsc_pkg;
    typedef enum logic [1:0]
    {
        ST_RUN = 2'h0,
        ST_GRANT = 2'h1,
        ST_SLEEP = 2'h3
    } pwr_state_type;
    // Clock enables toward the core, bus unit and interrupt unit
    typedef struct packed
    {
        logic core_en;
        logic bus_en;
        logic intc_en;
    } clk_gate_type;
    // Acknowledge bus transaction request
    typedef struct packed
    {
        logic valid;
        logic [1:0] kind;
    } ack_txn_type;
endpackage

/* rtl/sync_filter.sv */
// Three-flop input synchroniser; a change counts when stages two and three agree.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module sync_filter
#(
    parameter logic RESET_VAL = 1'b1
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Data
    input wire logic async_i,
    output logic level_o
);
    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic level_q;
    logic level_d;
    // Stage one is read only by stage two
    always_comb
    begin
        stage_d = {stage_q[1:0], async_i};
        level_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : level_q;
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            stage_q <= {3{RESET_VAL}};
            level_q <= RESET_VAL;
        end
        else
        begin
            stage_q <= stage_d;
            level_q <= level_d;
        end
    end
    assign level_o = level_q;
endmodule
`default_nettype wire

/* rtl/low_power_state_control.sv */
// Low-power state controller: Stop-Grant, Sleep and system-management entry.
// Assumes request pins are active low and asynchronous to core_clk_i;
// the bus side takes one acknowledge request per pulse on ack_o.valid.
`timescale 1ns/100ps
`default_nettype none
`include "lpsc_defines.svh"
module low_power_state_control
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Requests from system logic
    input wire logic stop_clock_req_n_i,
    input wire logic sleep_req_n_i,
    input wire logic sys_mgmt_irq_n_i,
    // Core events
    input wire logic snoop_i,
    input wire logic irq_i,
    input wire logic irq_serviced_i,
    // Clock gating and core control
    output lpsc_pkg::clk_gate_type clk_gate_o,
    output logic snoop_en_o,
    output logic irq_pending_o,
    output logic exec_en_o,
    output logic save_state_o,
    output logic system_management_mode_o,
    output logic handler_fetch_o,
    output lpsc_pkg::pwr_state_type state_o,
    // Acknowledge transaction request
    output lpsc_pkg::ack_txn_type ack_o,
    output logic snoop_seen_o
);
    import lpsc_pkg::*;

    logic rst_s1_q;
    logic rst_n_q;
    logic stop_req, sleep_req, mgmt_req;
    logic stop_n_s, sleep_n_s, mgmt_n_s;
    logic mgmt_prev_q, mgmt_prev_d;
    pwr_state_type state_q, state_d;
    clk_gate_type gate_q, gate_d;
    ack_txn_type ack_q, ack_d;
    logic pend_q, pend_d;
    logic mode_q, mode_d;
    logic save_q, save_d;
    logic fetch_q, fetch_d;
    logic snoop_seen_q, snoop_seen_d;
    logic exec_q, exec_d;
    logic snoop_en_q, snoop_en_d;
    logic [1:0] entry_step_q, entry_step_d;

    // Reset release through two flops; assertion is immediate
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // Request synchronisers; idle level is high for the active-low pins
    sync_filter #(.RESET_VAL(1'b1)) u_sync_stop
    (
        .clk_i(core_clk_i),
        .rst_n_i(rst_n_q),
        .async_i(stop_clock_req_n_i),
        .level_o(stop_n_s)
    );
    sync_filter #(.RESET_VAL(1'b1)) u_sync_sleep
    (
        .clk_i(core_clk_i),
        .rst_n_i(rst_n_q),
        .async_i(sleep_req_n_i),
        .level_o(sleep_n_s)
    );
    sync_filter #(.RESET_VAL(1'b1)) u_sync_mgmt
    (
        .clk_i(core_clk_i),
        .rst_n_i(rst_n_q),
        .async_i(sys_mgmt_irq_n_i),
        .level_o(mgmt_n_s)
    );

    assign stop_req = ~stop_n_s;
    assign sleep_req = ~sleep_n_s;
    assign mgmt_req = ~mgmt_n_s;

    // Gating per state; the bus unit clock is gated only in Sleep
    function automatic clk_gate_type gate_for(input pwr_state_type s);
        clk_gate_type g;
        g = '{core_en: 1'b1, bus_en: 1'b1, intc_en: 1'b1};
        case (s)
            ST_GRANT: g = '{core_en: 1'b0, bus_en: 1'b1, intc_en: 1'b1};
            ST_SLEEP: g = '{core_en: 1'b0, bus_en: 1'b0, intc_en: 1'b0};
            default: g = '{core_en: 1'b1, bus_en: 1'b1, intc_en: 1'b1};
        endcase
        return g;
    endfunction

    // State machine and its side effects
    always_comb
    begin
        state_d = state_q;
        ack_d = '{valid: 1'b0, kind: `LPSC_ACK_NONE};
        pend_d = pend_q;
        mode_d = mode_q;
        save_d = 1'b0;
        fetch_d = fetch_q;
        mgmt_prev_d = mgmt_req;
        entry_step_d = entry_step_q;
        case (state_q)
            ST_RUN:
            begin
                if (stop_req && entry_step_q == 2'h0)
                begin
                    state_d = ST_GRANT;
                    ack_d = '{valid: 1'b1, kind: `LPSC_ACK_STOP_GRANT};
                end
                // Sleep request here is ignored on purpose
            end
            ST_GRANT:
            begin
                if (sleep_req)
                begin
                    state_d = ST_SLEEP;
                end
                else if (!stop_req)
                begin
                    state_d = ST_RUN;
                end
            end
            ST_SLEEP:
            begin
                // Only the sleep request matters; other inputs are disregarded
                if (!sleep_req)
                begin
                    state_d = ST_GRANT;
                end
            end
            default:
            begin
                state_d = ST_RUN;
            end
        endcase
        // Interrupts latch while clocks to the interrupt unit run; set beats clear
        if (state_q != ST_SLEEP && irq_i)
        begin
            pend_d = 1'b1;
        end
        else if (state_q == ST_RUN && irq_serviced_i)
        begin
            pend_d = 1'b0;
        end
        // System-management entry only in Run, even with execution held off, edge of the request
        case (entry_step_q)
            2'h0:
            begin
                if (state_q == ST_RUN && !stop_req && mgmt_req && !mgmt_prev_q && !mode_q)
                begin
                    save_d = 1'b1;
                    entry_step_d = 2'h1;
                end
            end
            2'h1:
            begin
                mode_d = 1'b1;
                entry_step_d = 2'h3;
            end
            2'h3:
            begin
                ack_d = '{valid: 1'b1, kind: `LPSC_ACK_MGMT};
                entry_step_d = 2'h2;
            end
            2'h2:
            begin
                fetch_d = 1'b1;
                entry_step_d = 2'h0;
            end
            default:
            begin
                entry_step_d = 2'h0;
            end
        endcase
        gate_d = gate_for(state_d);
        // After a low-power stay, execution waits until the latched interrupt is serviced
        exec_d = (state_d == ST_RUN) && (exec_q || !pend_d);
        snoop_en_d = (state_d != ST_SLEEP);
        snoop_seen_d = snoop_i && (state_q != ST_SLEEP);
    end

    // Registers; reset returns the state to run with all clocks on, but execution and snoop enables off
    always_ff @(posedge core_clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= ST_RUN;
            gate_q <= '{core_en: 1'b1, bus_en: 1'b1, intc_en: 1'b1};
            ack_q <= '{valid: 1'b0, kind: `LPSC_ACK_NONE};
            pend_q <= 1'b0;
            mode_q <= 1'b0;
            save_q <= 1'b0;
            fetch_q <= 1'b0;
            mgmt_prev_q <= 1'b0;
            entry_step_q <= 2'h0;
            exec_q <= 1'b0;
            snoop_en_q <= 1'b0;
            snoop_seen_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            gate_q <= gate_d;
            ack_q <= ack_d;
            pend_q <= pend_d;
            mode_q <= mode_d;
            save_q <= save_d;
            fetch_q <= fetch_d;
            mgmt_prev_q <= mgmt_prev_d;
            entry_step_q <= entry_step_d;
            exec_q <= exec_d;
            snoop_en_q <= snoop_en_d;
            snoop_seen_q <= snoop_seen_d;
        end
    end

    assign clk_gate_o = gate_q;
    assign snoop_en_o = snoop_en_q;
    assign irq_pending_o = pend_q;
    assign exec_en_o = exec_q;
    assign save_state_o = save_q;
    assign system_management_mode_o = mode_q;
    assign handler_fetch_o = fetch_q;
    assign state_o = state_q;
    assign ack_o = ack_q;
    assign snoop_seen_o = snoop_seen_q;

    // Checks
    property p_grant_ack;
        @(posedge core_clk_i) disable iff (!rst_n_q)
        (state_q == ST_RUN && state_d == ST_GRANT) |=>
            ack_q.valid && ack_q.kind == `LPSC_ACK_STOP_GRANT;
    endproperty
    a_grant_ack: assert property (p_grant_ack) else $error("No stop-grant acknowledge");
    property p_grant_gate;
        @(posedge core_clk_i) disable iff (!rst_n_q)
        (state_q == ST_GRANT) |-> !gate_q.core_en && gate_q.bus_en && gate_q.intc_en;
    endproperty
    a_grant_gate: assert property (p_grant_gate) else $error("Bad stop-grant gating");
    property p_sleep_gate;
        @(posedge core_clk_i) disable iff (!rst_n_q)
        (state_q == ST_SLEEP) |-> gate_q == 3'h0 && !snoop_en_q;
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("Sleep clocks running");
    property p_sleep_entry;
        @(posedge core_clk_i) disable iff (!rst_n_q)
        (state_q == ST_SLEEP && $past(state_q) != ST_SLEEP) |-> $past(state_q) == ST_GRANT;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("Sleep not from grant");
    property p_sleep_exit;
        @(posedge core_clk_i) disable iff (!rst_n_q)
        (state_q == ST_SLEEP && !sleep_req) |=> state_q == ST_GRANT;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("Sleep exit missed");
    property p_irq_latch;
        @(posedge core_clk_i) disable iff (!rst_n_q)
        (state_q == ST_GRANT && irq_i) |=> irq_pending_o;
    endproperty
    a_irq_latch: assert property (p_irq_latch) else $error("Interrupt not latched");
    property p_sleep_irq;
        @(posedge core_clk_i) disable iff (!rst_n_q)
        (state_q == ST_SLEEP && !pend_q) |=> !pend_q;
    endproperty
    a_sleep_irq: assert property (p_sleep_irq) else $error("Interrupt taken in sleep");
    property p_mgmt_seq;
        @(posedge core_clk_i) disable iff (!rst_n_q)
        $rose(save_q) |=> mode_q ##1 (ack_q.valid && ack_q.kind == `LPSC_ACK_MGMT) ##1 fetch_q;
    endproperty
    a_mgmt_seq: assert property (p_mgmt_seq) else $error("Mode entry order wrong");
    property p_resume;
        @(posedge core_clk_i) disable iff (!rst_n_q)
        (state_q == ST_GRANT && !stop_req && !sleep_req) |=> state_q == ST_RUN ##1 gate_q.core_en;
    endproperty
    a_resume: assert property (p_resume) else $error("Resume failed");
endmodule
`default_nettype wire

/* verif/pm_chipset_model.sv */
// Behavioural system logic that drives the three low-power request pins.
// Assumes the bench commands levels; the pins follow off the clock grid.
`timescale 1ns/100ps
`default_nettype none
module pm_chipset_model
#(
    parameter real SKEW = 1.3
)
(
    // Commanded request levels, high means asserted
    input wire logic stop_want_i,
    input wire logic sleep_want_i,
    input wire logic mgmt_want_i,
    // Active-low request pins toward the device
    output logic stop_clock_req_n_o,
    output logic sleep_req_n_o,
    output logic sys_mgmt_irq_n_o
);
    // Pins start deasserted so nothing is requested out of reset
    initial
    begin
        stop_clock_req_n_o = 1'b1;
        sleep_req_n_o = 1'b1;
        sys_mgmt_irq_n_o = 1'b1;
    end
    // Skew puts every change between clock edges, as unclocked logic would
    always @(stop_want_i) stop_clock_req_n_o <= #(SKEW) ~stop_want_i;
    always @(sleep_want_i) sleep_req_n_o <= #(SKEW) ~sleep_want_i;
    always @(mgmt_want_i) sys_mgmt_irq_n_o <= #(SKEW) ~mgmt_want_i;
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the low-power state controller.
// Assumes the chipset model drives the request pins; core events come from here.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import lpsc_pkg::*;
    logic clk, arst_n, snoop, irq, irq_serviced, stop_want, sleep_want, mgmt_want;
    logic stop_n, sleep_n, mgmt_n;
    logic snoop_en, irq_pending, exec_en, save_state, mode, fetch, snoop_seen;
    clk_gate_type gate;
    pwr_state_type state;
    ack_txn_type ack;
    int fail_count;
    int tests_run;

    pm_chipset_model partner (.stop_want_i(stop_want), .sleep_want_i(sleep_want),
        .mgmt_want_i(mgmt_want), .stop_clock_req_n_o(stop_n), .sleep_req_n_o(sleep_n),
        .sys_mgmt_irq_n_o(mgmt_n));

    low_power_state_control uut (.core_clk_i(clk), .arst_n_i(arst_n),
        .stop_clock_req_n_i(stop_n), .sleep_req_n_i(sleep_n), .sys_mgmt_irq_n_i(mgmt_n),
        .snoop_i(snoop), .irq_i(irq), .irq_serviced_i(irq_serviced), .clk_gate_o(gate),
        .snoop_en_o(snoop_en), .irq_pending_o(irq_pending), .exec_en_o(exec_en),
        .save_state_o(save_state), .system_management_mode_o(mode),
        .handler_fetch_o(fetch), .state_o(state), .ack_o(ack), .snoop_seen_o(snoop_seen));

    // 250 MHz core clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Bounded wait; sel 0 for a state, 1 for an acknowledge, 2 for the save pulse
    task automatic wait_until(input int sel, input pwr_state_type s);
        for (int i = 0; i < 20; i++)
        begin
            @(negedge clk);
            if ((sel == 0 && state === s) || (sel == 1 && ack.valid === 1'b1) ||
                (sel == 2 && save_state === 1'b1))
                return;
        end
        fail_count++;
        report_and_stop();
    endtask

    // Values six cycles after reset release
    task automatic t_reset();
        check({state, gate, ack}, {ST_RUN, 3'h7, 3'h0});
        check({snoop_en, exec_en, mode, fetch, irq_pending}, 5'h18);
    endtask

    // Sleep outside Stop-Grant must be ignored
    task automatic t_sleep_in_run();
        sleep_want = 1'b1;
        cycles(10);
        check({state, gate}, {ST_RUN, 3'h7});
        sleep_want = 1'b0;
        cycles(8);
    endtask

    // Entry to Stop-Grant; the synchroniser delays any reaction
    task automatic t_stop_enter();
        stop_want = 1'b1;
        cycles(2);
        check(state, ST_RUN);
        wait_until(1, ST_RUN);
        check({state, ack.kind}, {ST_GRANT, 2'h1});
        check(gate, 3'h3);
        snoop = 1'b1;
        cycles(1);
        check(ack.valid, 1'b0);
        check({exec_en, snoop_en, snoop_seen}, 3'h3);
        snoop = 1'b0;
    endtask

    // Sleep from Stop-Grant ignores snoops, interrupts and the management request
    task automatic t_sleep();
        sleep_want = 1'b1;
        wait_until(0, ST_SLEEP);
        check(gate, 3'h0);
        snoop = 1'b1;
        irq = 1'b1;
        cycles(2);
        check({snoop_seen, snoop_en, irq_pending}, 3'h0);
        snoop = 1'b0;
        irq = 1'b0;
        mgmt_want = 1'b1;
        cycles(8);
        check({state, mode, save_state}, {ST_SLEEP, 2'h0});
        mgmt_want = 1'b0;
        sleep_want = 1'b0;
        wait_until(0, ST_GRANT);
        check(gate, 3'h3);
    endtask

    // Interrupt latched in Stop-Grant is serviced before execution resumes
    task automatic t_stop_exit();
        irq = 1'b1;
        cycles(1);
        irq = 1'b0;
        cycles(1);
        check(irq_pending, 1'b1);
        stop_want = 1'b0;
        wait_until(0, ST_RUN);
        check({gate, irq_pending, exec_en}, {3'h7, 2'h2});
        cycles(1);
        check(exec_en, 1'b0);
        irq_serviced = 1'b1;
        cycles(1);
        irq_serviced = 1'b0;
        cycles(2);
        check({irq_pending, exec_en}, 2'h1);
    endtask

    // Management entry walk: save, mode, acknowledge, handler fetch
    task automatic t_mgmt();
        mgmt_want = 1'b1;
        wait_until(2, ST_RUN);
        check(mode, 1'b0);
        cycles(1);
        check({mode, save_state}, 2'h2);
        cycles(1);
        check({ack, fetch}, {1'b1, 2'h2, 1'b0});
        cycles(1);
        check({fetch, ack.valid, mode}, 3'h5);
        mgmt_want = 1'b0;
    endtask

    // Reset in mid-run clears the sticky mode and quiets the outputs
    task automatic t_reset_mid();
        arst_n = 1'b0;
        cycles(2);
        check({state, gate, ack}, {ST_RUN, 3'h7, 3'h0});
        check({mode, fetch, exec_en, snoop_en}, 4'h0);
        arst_n = 1'b1;
        cycles(6);
        check({mode, exec_en}, 2'h1);
    endtask

    // Main sequence; reset held for four cycles
    initial
    begin
        arst_n = 1'b0;
        snoop = 1'b0;
        irq = 1'b0;
        irq_serviced = 1'b0;
        stop_want = 1'b0;
        sleep_want = 1'b0;
        mgmt_want = 1'b0;
        fail_count = 0;
        tests_run = 0;
        cycles(4);
        arst_n = 1'b1;
        cycles(6);
        t_reset();
        t_sleep_in_run();
        t_stop_enter();
        t_sleep();
        t_stop_exit();
        t_mgmt();
        t_reset_mid();
        report_and_stop();
    end
endmodule
`default_nettype wire
